// >>> aurx_routing.sv
// Purpose: Setting registers, input routing and output clock/data selection
// Assumes: PLL, demodulator and flag logic sit outside and share clk
// Notes:   Settings are write-only; state is visible only on the output pins
`timescale 1ns/1ps
`include "aurx_defs.svh"
module aurx_routing #(
  parameter int XTAL_PER_FRAME = `AURX_XTAL_PER_FRAME
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ccbClk,
  input  wire logic       ccbCe,
  input  wire logic       ccbDi,
  input  wire logic       chipAddrUpper,
  input  wire logic       chipAddrLower,
  input  wire logic       crystalInput,
  input  wire logic [6:0] rxIn,
  input  wire logic       serialAudioInput,
  input  wire logic       pllLocked,
  input  wire logic       pllBitClock,
  input  wire logic       pllFrameClock,
  input  wire logic       pllError,
  input  wire logic       demodData,
  input  wire logic [7:0] irqEvents,
  output logic [6:0]      demodSelect,
  output logic            demodPulldown,
  output logic            passthroughOutput,
  output logic            oscAmpRun,
  output logic            sBitClock,
  output logic            sFrameClock,
  output logic            rBitClock,
  output logic            rFrameClock,
  output logic            audioData,
  output logic            outputFormatChoice,
  output logic            receiveErrorPin,
  output logic            irqPin
);
  import aurx_pkg::*;

  logic       wrValid;
  logic [3:0] wrCmd;
  logic [7:0] wrData;
  logic [1:0] chipAddr;
  logic       xtalFrame, xtalBit;

  // Setting registers, field byte only
  logic [7:0] ampCfg_r, sClkCfg_r, clkData_r, dataIo_r, format_r, irqEn_r, errCfg_r;
  logic [7:0] ampCfg_nxt, sClkCfg_nxt, clkData_nxt, dataIo_nxt, format_nxt;
  logic [7:0] irqEn_nxt, errCfg_nxt;

  // Pin synchronisers: first stage read only by the second
  logic [13:0] pinMeta_r, pinSync_r;
  logic        xtalLast_r;
  logic [1:0]  strapMeta_r, strapSync_r;

  logic        useXtal_r, useXtal_nxt;
  logic        errHold_r, errHold_nxt;
  logic [6:0]  demodSel_nxt;
  logic        pulldown_nxt, pass_nxt, amp_nxt;
  logic        sBit_nxt, sFrame_nxt, rBit_nxt, rFrame_nxt, data_nxt;
  logic        err_nxt, irq_nxt;
  aurx_dsrc_t  dsrc;

  logic [6:0]  rxS;
  logic        xtalS, sdinS, pBitS, pFrameS, xtalRise;

  assign rxS = pinSync_r[6:0];
  assign xtalS = pinSync_r[7];
  assign sdinS = pinSync_r[8];
  assign pBitS = pinSync_r[9];
  assign pFrameS = pinSync_r[10];
  assign chipAddr = strapSync_r;

  function automatic logic [6:0] onehot7(input logic [2:0] sel);
    logic [6:0] v;
    v = 7'h00;
    if (sel != `AURX_SEL_NONE)
      v[sel] = 1'b1;
    return v;
  endfunction

  aurx_ccb_rx u_ccb (
    .clk      (clk),
    .rst_n    (rst_n),
    .ccbClk   (ccbClk),
    .ccbCe    (ccbCe),
    .ccbDi    (ccbDi),
    .chipAddr (chipAddr),
    .wrValid  (wrValid),
    .wrCmd    (wrCmd),
    .wrData   (wrData)
  );

  aurx_xtal_div #(
    .XTAL_PER_FRAME (XTAL_PER_FRAME)
  ) u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .xtalRise  (xtalRise),
    .xtalLevel (xtalS),
    .frameRate (sClkCfg_r[`AURX_SFR_HI:`AURX_SFR_LO]),
    .bitRate   (sClkCfg_r[`AURX_SBR_HI:`AURX_SBR_LO]),
    .frameClk  (xtalFrame),
    .bitClk    (xtalBit)
  );

  // Register writes; unknown commands fall through untouched
  always_comb
  begin
    ampCfg_nxt = ampCfg_r;
    sClkCfg_nxt = sClkCfg_r;
    clkData_nxt = clkData_r;
    dataIo_nxt = dataIo_r;
    format_nxt = format_r;
    irqEn_nxt = irqEn_r;
    errCfg_nxt = errCfg_r;
    if (wrValid)
    begin
      unique case (wrCmd)
        `AURX_CMD_MASTER_CLK: ampCfg_nxt = wrData;
        `AURX_CMD_S_CLK: sClkCfg_nxt = wrData;
        `AURX_CMD_CLK_DATA: clkData_nxt = wrData;
        `AURX_CMD_DATA_IO: dataIo_nxt = wrData;
        `AURX_CMD_FORMAT: format_nxt = wrData;
        `AURX_CMD_IRQ_EN: irqEn_nxt = wrData;
        `AURX_CMD_ERR_OUT: errCfg_nxt = wrData;
        default: ;
      endcase
    end
  end

  // Clock source, oscillator and error hold
  always_comb
  begin
    logic [1:0] ampMode;
    logic       ampRuns;
    ampMode = ampCfg_r[`AURX_AMP_HI:`AURX_AMP_LO];
    // Auto mode stops the amp while locked; stop mode always
    ampRuns = (ampMode == `AURX_AMP_CONT) ||
              (ampMode == `AURX_AMP_AUTO && !pllLocked);
    amp_nxt = ampRuns;
    // Crystal when forced, or when the PLL has no lock; lock need not drop
    useXtal_nxt = clkData_r[`AURX_CSRC_BIT] | ~pllLocked;
    // Crystal edges are only counted while the amp runs: auto mode stops the crystal clocks while locked, except the bit clock at bit rate code 2
    xtalRise = xtalS & ~xtalLast_r & ampRuns;
    errHold_nxt = errHold_r;
    // A switch disturbs the error pin only if neither exemption applies
    if (useXtal_nxt != useXtal_r && ampMode != `AURX_AMP_CONT &&
        !errCfg_r[`AURX_RATE_CHANGE_ERROR_CHOICE_BIT])
      errHold_nxt = 1'b1;
    else if (xtalRise | ~useXtal_r)
      errHold_nxt = 1'b0;
    err_nxt = pllError | errHold_r;
  end

  // Routing, clocks, data and interrupt
  always_comb
  begin
    logic [2:0] dSel;
    logic [2:0] pSel;
    logic       bitSrc;
    logic       frameSrc;
    dSel = dataIo_r[`AURX_DEMOD_HI:`AURX_DEMOD_LO];
    pSel = dataIo_r[`AURX_PASS_HI:`AURX_PASS_LO];
    demodSel_nxt = onehot7(dSel);
    pulldown_nxt = (dSel == `AURX_SEL_NONE);
    pass_nxt = |(onehot7(pSel) & rxS);
    // R and S pairs come from the same source each cycle
    bitSrc = useXtal_r ? xtalBit : pBitS;
    frameSrc = useXtal_r ? xtalFrame : pFrameS;
    sBit_nxt = bitSrc ^ format_r[`AURX_SBP_BIT];
    rBit_nxt = bitSrc ^ format_r[`AURX_RBP_BIT];
    // Frame clock inverted when its polarity bit is set so right data falls in the low phase
    sFrame_nxt = frameSrc ^ format_r[`AURX_SFP_BIT];
    rFrame_nxt = frameSrc ^ format_r[`AURX_RFP_BIT];
    // Data choice is its own setting, not tied to the clock source
    if (!clkData_r[`AURX_COND_BIT])
    begin
      if (pllLocked)
        dsrc = OUT_DEMOD;
      else
        dsrc = clkData_r[`AURX_UNLK_BIT] ? OUT_MUTE : OUT_SERIAL;
    end
    else if (clkData_r[`AURX_MUTE_BIT] | clkData_r[`AURX_UNLK_BIT])
      dsrc = OUT_MUTE;
    else
      dsrc = OUT_SERIAL;
    unique case (dsrc)
      OUT_DEMOD: data_nxt = demodData;
      OUT_SERIAL: data_nxt = sdinS;
      default: data_nxt = 1'b0;
    endcase
    // Disabled conditions never reach the pin, channel-status bit included
    irq_nxt = |(irqEvents & irqEn_r);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ampCfg_r <= `AURX_RST_MASTER_CLK;
      sClkCfg_r <= `AURX_RST_S_CLK;
      clkData_r <= `AURX_RST_CLK_DATA;
      dataIo_r <= `AURX_RST_DATA_IO;
      format_r <= `AURX_RST_FORMAT;
      irqEn_r <= `AURX_RST_IRQ_EN;
      errCfg_r <= `AURX_RST_ERR_OUT;
      pinMeta_r <= 14'h0000;
      pinSync_r <= 14'h0000;
      xtalLast_r <= 1'b0;
      strapMeta_r <= 2'h0;
      strapSync_r <= 2'h0;
      useXtal_r <= 1'b1;
      errHold_r <= 1'b0;
      demodSelect <= 7'h01;
      demodPulldown <= 1'b0;
      passthroughOutput <= 1'b0;
      oscAmpRun <= 1'b1;
      sBitClock <= 1'b0;
      sFrameClock <= 1'b0;
      rBitClock <= 1'b0;
      rFrameClock <= 1'b0;
      audioData <= 1'b0;
      outputFormatChoice <= 1'b0;
      receiveErrorPin <= 1'b0;
      irqPin <= 1'b0;
    end
    else
    begin
      ampCfg_r <= ampCfg_nxt;
      sClkCfg_r <= sClkCfg_nxt;
      clkData_r <= clkData_nxt;
      dataIo_r <= dataIo_nxt;
      format_r <= format_nxt;
      irqEn_r <= irqEn_nxt;
      errCfg_r <= errCfg_nxt;
      pinMeta_r <= {3'h0, pllFrameClock, pllBitClock, serialAudioInput, crystalInput, rxIn};
      pinSync_r <= pinMeta_r;
      xtalLast_r <= xtalS;
      strapMeta_r <= {chipAddrUpper, chipAddrLower};
      strapSync_r <= strapMeta_r;
      useXtal_r <= useXtal_nxt;
      errHold_r <= errHold_nxt;
      demodSelect <= demodSel_nxt;
      demodPulldown <= pulldown_nxt;
      passthroughOutput <= pass_nxt;
      oscAmpRun <= amp_nxt;
      sBitClock <= sBit_nxt;
      sFrameClock <= sFrame_nxt;
      rBitClock <= rBit_nxt;
      rFrameClock <= rFrame_nxt;
      audioData <= data_nxt;
      outputFormatChoice <= format_r[`AURX_FMT_BIT];
      receiveErrorPin <= err_nxt;
      irqPin <= irq_nxt;
    end
  end
endmodule

// >>> aurx_defs.svh
// Purpose: Constants of the audio receiver routing and configuration block
// Assumes: Setting words arrive as address byte plus two data bytes
// Notes:   Field bit positions count within the second byte; command and chip-address bits within the first
`ifndef AURX_DEFS_SVH
`define AURX_DEFS_SVH

`define AURX_DEV_ADDR        8'hE8
`define AURX_CMD_MASTER_CLK  4'h2
`define AURX_CMD_S_CLK       4'h4
`define AURX_CMD_CLK_DATA    4'h5
`define AURX_CMD_DATA_IO     4'h6
`define AURX_CMD_FORMAT      4'h7
`define AURX_CMD_IRQ_EN      4'h8
`define AURX_CMD_ERR_OUT     4'h9

`define AURX_CMD_HI          7
`define AURX_CMD_LO          4
`define AURX_CAU_BIT         1
`define AURX_CAL_BIT         0

`define AURX_AMP_HI          7
`define AURX_AMP_LO          6
`define AURX_SFR_HI          7
`define AURX_SFR_LO          6
`define AURX_SBR_HI          5
`define AURX_SBR_LO          4
`define AURX_MUTE_BIT        6
`define AURX_COND_BIT        5
`define AURX_UNLK_BIT        4
`define AURX_CSRC_BIT        1
`define AURX_PASS_HI         6
`define AURX_PASS_LO         4
`define AURX_DEMOD_HI        2
`define AURX_DEMOD_LO        0
`define AURX_SFP_BIT         7
`define AURX_SBP_BIT         6
`define AURX_RFP_BIT         5
`define AURX_RBP_BIT         4
`define AURX_FMT_BIT         0
`define AURX_CHSTAT_BIT      3
`define AURX_RATE_CHANGE_ERROR_CHOICE_BIT       5

`define AURX_RST_MASTER_CLK  8'h00
`define AURX_RST_S_CLK       8'h00
`define AURX_RST_CLK_DATA    8'h10
`define AURX_RST_DATA_IO     8'h00
`define AURX_RST_FORMAT      8'h00
`define AURX_RST_IRQ_EN      8'h00
`define AURX_RST_ERR_OUT     8'h00

`define AURX_SEL_NONE        3'h7
`define AURX_AMP_CONT        2'h0
`define AURX_AMP_AUTO        2'h2
`define AURX_AMP_STOP        2'h3
`define AURX_RATE_MUTED      2'h3
`define AURX_XTAL_PER_FRAME  256

`endif

// >>> aurx_pkg.sv
// Purpose: Types shared by the audio receiver routing block
// Assumes: Nothing beyond the defs header
// Notes:   Constants live in aurx_defs.svh
package aurx_pkg;
  typedef enum logic [1:0] {
    CCB_IDLE = 2'b00,
    CCB_ADDR = 2'b01,
    CCB_DATA = 2'b10
  } aurx_ccb_st_t;

  typedef enum logic [1:0] {
    OUT_DEMOD = 2'b00,
    OUT_SERIAL = 2'b01,
    OUT_MUTE = 2'b10
  } aurx_dsrc_t;
endpackage

// >>> aurx_ccb_rx.sv
// Purpose: Serial control bus receiver delivering one setting word per burst
// Assumes: Bus pins are asynchronous to clk and far slower than it
// Notes:   Bits arrive least significant first on rising bus clock edges
`timescale 1ns/1ps
`include "aurx_defs.svh"
module aurx_ccb_rx (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ccbClk,
  input  wire logic       ccbCe,
  input  wire logic       ccbDi,
  input  wire logic [1:0] chipAddr,
  output logic            wrValid,
  output logic [3:0]      wrCmd,
  output logic [7:0]      wrData
);
  import aurx_pkg::*;

  logic [2:0]   meta_r, sync_r, last_r;
  logic [2:0]   meta_nxt, sync_nxt, last_nxt;
  aurx_ccb_st_t st_r, st_nxt;
  logic [15:0]  sh_r, sh_nxt;
  logic [4:0]   cnt_r, cnt_nxt;
  logic         valid_nxt;
  logic [3:0]   cmd_nxt;
  logic [7:0]   data_nxt;
  logic         clkRise, ceRise, ceFall;

  always_comb
  begin
    meta_nxt = {ccbClk, ccbCe, ccbDi};
    sync_nxt = meta_r;
    last_nxt = sync_r;
    clkRise = sync_r[2] & ~last_r[2];
    ceRise = sync_r[1] & ~last_r[1];
    ceFall = ~sync_r[1] & last_r[1];
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    valid_nxt = 1'b0;
    cmd_nxt = wrCmd;
    data_nxt = wrData;
    unique case (st_r)
      CCB_IDLE:
      begin
        if (~sync_r[1])
        begin
          st_nxt = CCB_ADDR;
          cnt_nxt = 5'h00;
        end
      end
      CCB_ADDR:
      begin
        if (clkRise & ~sync_r[1])
        begin
          sh_nxt = {sync_r[0], sh_r[15:1]};
          cnt_nxt = cnt_r + 5'h01;
        end
        if (ceRise)
        begin
          // Only a full address byte naming this device opens a data phase
          if (cnt_r == 5'h08 && sh_r[15:8] == `AURX_DEV_ADDR)
            st_nxt = CCB_DATA;
          else
            st_nxt = CCB_IDLE;
          cnt_nxt = 5'h00;
        end
      end
      CCB_DATA:
      begin
        if (clkRise & sync_r[1] & (cnt_r != 5'h1F))
        begin
          sh_nxt = {sync_r[0], sh_r[15:1]};
          cnt_nxt = cnt_r + 5'h01;
        end
        if (ceFall)
        begin
          // Short or long bursts and foreign chip addresses are dropped whole
          if (cnt_r == 5'h10 && sh_r[1:0] == chipAddr)
          begin
            valid_nxt = 1'b1;
            cmd_nxt = sh_r[`AURX_CMD_HI:`AURX_CMD_LO];
            data_nxt = sh_r[15:8];
          end
          st_nxt = CCB_ADDR;
          cnt_nxt = 5'h00;
        end
      end
      default:
        st_nxt = CCB_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 3'h3;
      sync_r <= 3'h3;
      last_r <= 3'h3;
      st_r <= CCB_IDLE;
      sh_r <= 16'h0000;
      cnt_r <= 5'h00;
      wrValid <= 1'b0;
      wrCmd <= 4'h0;
      wrData <= 8'h00;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      wrValid <= valid_nxt;
      wrCmd <= cmd_nxt;
      wrData <= data_nxt;
    end
  end
endmodule

// >>> aurx_xtal_div.sv
// Purpose: Crystal-source bit and frame clocks from one shared divider
// Assumes: xtalRise is a one-cycle pulse per crystal period
// Notes:   One counter feeds the frame clock and bit rate codes 0 and 1; bit rate code 2 passes the crystal level
`timescale 1ns/1ps
`include "aurx_defs.svh"
module aurx_xtal_div #(
  parameter int XTAL_PER_FRAME = `AURX_XTAL_PER_FRAME
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       xtalRise,
  input  wire logic       xtalLevel,
  input  wire logic [1:0] frameRate,
  input  wire logic [1:0] bitRate,
  output logic            frameClk,
  output logic            bitClk
);
  localparam int CW = $clog2(XTAL_PER_FRAME);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          frame_nxt, bit_nxt;

  always_comb
  begin
    cnt_nxt = xtalRise ? cnt_r + {{(CW-1){1'b0}}, 1'b1} : cnt_r;
    // Each faster frame rate halves the divider tap; code 3 holds it muted
    unique case (frameRate)
      2'h0: frame_nxt = cnt_r[CW-1];
      2'h1: frame_nxt = cnt_r[CW-2];
      2'h2: frame_nxt = cnt_r[CW-3];
      default: frame_nxt = 1'b0;
    endcase
    unique case (bitRate)
      2'h0: bit_nxt = cnt_r[1];
      2'h1: bit_nxt = cnt_r[0];
      2'h2: bit_nxt = xtalLevel;
      default: bit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      frameClk <= 1'b0;
      bitClk <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      frameClk <= frame_nxt;
      bitClk <= bit_nxt;
    end
  end
endmodule

// >>> aurx_routing_asserts.sv
// Purpose: Port-level checks of the routing and configuration block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Settings are write-only, so checks tie outputs to input pins
`timescale 1ns/1ps
`include "aurx_defs.svh"
module aurx_routing_asserts #(
  parameter int XTAL_PER_FRAME = `AURX_XTAL_PER_FRAME
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ccbCe,
  input  wire logic [6:0] rxIn,
  input  wire logic       pllError,
  input  wire logic [7:0] irqEvents,
  input  wire logic [6:0] demodSelect,
  input  wire logic       demodPulldown,
  input  wire logic       passthroughOutput,
  input  wire logic       oscAmpRun,
  input  wire logic       sFrameClock,
  input  wire logic       rFrameClock,
  input  wire logic       outputFormatChoice,
  input  wire logic       receiveErrorPin,
  input  wire logic       irqPin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [4:0] sinceFall_r;
  logic [4:0] sinceFall_nxt;
  logic       ceDly_r;
  logic       ceDly_nxt;

  // Age of the last word end, saturating; settings may only move shortly after one
  always_comb
  begin
    ceDly_nxt = ccbCe;
    sinceFall_nxt = sinceFall_r + {4'h0, sinceFall_r != 5'h1F};
    if (ceDly_r && !ccbCe)
      sinceFall_nxt = 5'h00;
  end

  always_ff @(posedge clk)
  begin
    ceDly_r     <= ceDly_nxt;
    sinceFall_r <= rst_n ? sinceFall_nxt : 5'h1F;
  end

  sequence rxQuiet;
    (rxIn == 7'h00) [*6];
  endsequence
  sequence evQuiet;
    (irqEvents == 8'h00) [*3];
  endsequence
  sequence errHeld;
    pllError [*2];
  endsequence

  a_select_onehot: assert property (demodPulldown ? demodSelect == 7'h00 : $onehot(demodSelect))
    else $error("demod select not one-hot or not cleared");
  a_pass_quiet: assert property (rxQuiet |-> !passthroughOutput)
    else $error("pass-through high with all inputs low");
  a_irq_quiet: assert property (evQuiet |-> !irqPin)
    else $error("interrupt pin high without any event");
  a_irq_cause: assert property ($rose(irqPin) |-> ($past(irqEvents) != 8'h00) || ($past(irqEvents, 2) != 8'h00))
    else $error("interrupt pin rose without a recent event");
  a_reset_defaults: assert property ($rose(rst_n) |-> demodSelect == 7'h01 && oscAmpRun && !irqPin && !demodPulldown)
    else $error("outputs not at defaults after reset");
  a_err_follows: assert property (errHeld |-> receiveErrorPin)
    else $error("error pin low while error input held");
  a_frames_aligned: assert property ($changed(sFrameClock) |-> $changed(rFrameClock))
    else $error("frame clocks moved out of step");
  a_setting_age: assert property (($changed(demodSelect) || $changed(outputFormatChoice)) |-> sinceFall_r < 5'h10)
    else $error("setting changed with no recent bus word");
endmodule

bind aurx_routing aurx_routing_asserts #(.XTAL_PER_FRAME(XTAL_PER_FRAME)) chk (
  .clk, .rst_n, .ccbCe, .rxIn, .pllError, .irqEvents, .demodSelect, .demodPulldown,
  .passthroughOutput, .oscAmpRun, .sFrameClock, .rFrameClock, .outputFormatChoice,
  .receiveErrorPin, .irqPin
);

// >>> aurx_host_model.sv
// Purpose: Host side of the serial control bus, one setting word per call
// Assumes: Each bus level held 5 clk, above the 4 clk the receiver needs
// Notes:   Bus clock stands still low between words
`timescale 1ns/1ps
module aurx_host_model (
  input  wire logic clk,
  output logic      ccbClk,
  output logic      ccbCe,
  output logic      ccbDi
);
  initial
  begin
    ccbClk <= 1'b0;
    ccbCe  <= 1'b0;
    ccbDi  <= 1'b1;
  end

  task automatic hold();
    repeat (5) @(posedge clk);
  endtask

  // Least significant bit first, taken on the rising bus clock
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      ccbClk <= 1'b0;
      ccbDi  <= v[i];
      hold();
      ccbClk <= 1'b1;
      hold();
    end
  endtask

  task automatic send(input logic [7:0] dev, input logic [7:0] cmdByte, input logic [7:0] fld);
    @(posedge clk);
    shift({8'h00, dev}, 8);
    ccbClk <= 1'b0;
    ccbCe  <= 1'b1;
    hold();
    shift({fld, cmdByte}, 16);
    ccbClk <= 1'b0;
    hold();
    ccbCe <= 1'b0;
    // A released data line must not look like the last bit
    ccbDi <= ~fld[7];
    hold();
  endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the routing and configuration block
// Assumes: Host model writes settings; bench plays PLL, inputs and events
// Notes:   Crystal divider shortened to 32 edges per 48 kHz frame
`timescale 1ns/1ps
`include "aurx_defs.svh"
module tb_top;
  import aurx_pkg::*;
  typedef struct {int sel; logic [15:0] val;} aurx_note_t;
  localparam logic [7:0] DFLD [6] = '{8'h10, 8'h10, 8'h00, 8'h20, 8'h60, 8'h22};
  localparam logic       DLK [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [1:0] DKIND [6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1};

  logic       clk, rst_n, ccbClk, ccbCe, ccbDi, crystalInput, serialAudioInput;
  logic       pllLocked, pllBitClock, pllFrameClock, pllError, demodData;
  logic [6:0] rxIn, demodSelect;
  logic [7:0] irqEvents;
  logic [7:0] pcnt = 8'h00;
  logic       demodPulldown, passthroughOutput, oscAmpRun, sBitClock, sFrameClock;
  logic       rBitClock, rFrameClock, audioData, outputFormatChoice, receiveErrorPin, irqPin;
  int         bad_count, num_checks, cyc, edges;
  aurx_note_t noteQ[$];
  event       look;

  aurx_routing #(.XTAL_PER_FRAME(32)) DUT (
    .clk, .rst_n, .ccbClk, .ccbCe, .ccbDi, .chipAddrUpper(1'b1), .chipAddrLower(1'b0),
    .crystalInput, .rxIn, .serialAudioInput, .pllLocked, .pllBitClock, .pllFrameClock,
    .pllError, .demodData, .irqEvents, .demodSelect, .demodPulldown, .passthroughOutput,
    .oscAmpRun, .sBitClock, .sFrameClock, .rBitClock, .rFrameClock, .audioData,
    .outputFormatChoice, .receiveErrorPin, .irqPin
  );
  aurx_host_model host (.clk, .ccbClk, .ccbCe, .ccbDi);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Crystal runs free, unrelated in phase to clk
  initial
  begin
    crystalInput = 1'b0;
    #13;
    forever #200 crystalInput = ~crystalInput;
  end

  always @(posedge clk)
  begin
    pcnt <= pcnt + 8'h01;
    pllBitClock <= pcnt[1];
    pllFrameClock <= pcnt[6];
    cyc++;
    if (cyc > 40000)
    begin
      bad_count++;
      summarize();
    end
  end

  always @(look)
  begin
    aurx_note_t n;
    logic [15:0] got;
    while (noteQ.size() > 0)
    begin
      n = noteQ.pop_front();
      case (n.sel)
        0: got = {8'h00, demodPulldown, demodSelect};
        1: got = {15'h0000, passthroughOutput};
        2: got = {15'h0000, irqPin};
        3: got = {15'h0000, audioData};
        4: got = {15'h0000, oscAmpRun};
        5: got = {15'h0000, receiveErrorPin};
        6: got = {15'h0000, outputFormatChoice};
        8: got = {12'h000, sFrameClock, rFrameClock, sBitClock, rBitClock};
        default: got = 16'(edges);
      endcase
      num_checks++;
      if (got !== n.val)
      begin
        bad_count++;
        $display("MISMATCH t=%0t sel=%0d got=%h exp=%h", $time, n.sel, got, n.val);
      end
    end
  end

  task automatic chk(input int s, input logic [15:0] v);
    @(negedge clk);
    noteQ.push_back('{s, v});
    -> look;
  endtask

  task automatic wr(input logic [3:0] cmd, input logic [7:0] fld);
    host.send(8'hE8, {cmd, 4'h2}, fld);
    repeat (6) @(posedge clk);
  endtask

  // Rising frame-clock edges over 1024 cycles: four frames at 48 kHz
  task automatic count();
    logic prev;
    edges = 0;
    prev = sFrameClock;
    repeat (1024)
    begin
      @(negedge clk);
      if (sFrameClock === 1'b1 && prev === 1'b0)
        edges++;
      prev = sFrameClock;
    end
  endtask

  task automatic done(input string nm);
    $display("test %s done, checks %0d", nm, num_checks);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [7:0] m;
    logic [2:0] p;
    rst_n = 1'b0;
    serialAudioInput = 1'b0;
    pllLocked = 1'b1;
    pllError = 1'b0;
    demodData = 1'b0;
    rxIn = 7'h00;
    irqEvents = 8'h00;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    void'($urandom(32'hFA5D33BC));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(0, 16'h0001);
    chk(4, 16'h0001);
    chk(2, 16'h0000);
    done("reset");
    for (int c = 0; c < 8; c++)
    begin
      p = 3'(7 - c);
      wr(4'h6, {1'b0, p, 1'b0, 3'(c)});
      rxIn <= 7'($urandom);
      repeat (5) @(posedge clk);
      chk(0, (c == 7) ? 16'h0080 : 16'(1 << c));
      chk(1, (p == 3'h7) ? 16'h0000 : {15'h0000, rxIn[p]});
    end
    host.send(8'hE9, 8'h62, 8'h03);
    host.send(8'hE8, 8'h61, 8'h03);
    host.send(8'hE8, 8'h32, 8'h03);
    repeat (6) @(posedge clk);
    chk(0, 16'h0080);
    done("routing");
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'h08 : 8'($urandom);
      wr(4'h8, m);
      for (int k = 0; k < 4; k++)
      begin
        irqEvents <= (k == 0) ? 8'h08 : 8'($urandom);
        repeat (2) @(posedge clk);
        chk(2, {15'h0000, |(irqEvents & m)});
      end
    end
    irqEvents <= 8'h00;
    done("irq");
    for (int i = 0; i < 12; i++)
    begin
      pllLocked <= DLK[i / 2];
      demodData <= i[0];
      serialAudioInput <= ~i[0];
      wr(4'h5, DFLD[i / 2]);
      chk(3, (DKIND[i / 2] == 2'h2) ? 16'h0000 : {15'h0000, i[0] ^ (DKIND[i / 2] == 2'h1)});
    end
    chk(5, 16'h0000);
    done("data");
    wr(4'h5, 8'h10);
    pllError <= 1'b1;
    repeat (3) @(posedge clk);
    chk(5, 16'h0001);
    pllError <= 1'b0;
    wr(4'h2, 8'h80);
    chk(4, 16'h0000);
    pllLocked <= 1'b0;
    repeat (4) @(posedge clk);
    chk(4, 16'h0001);
    pllLocked <= 1'b1;
    wr(4'h5, 8'h12);
    chk(5, 16'h0001);
    count();
    chk(7, 16'h0000);
    wr(4'h9, 8'h20);
    wr(4'h5, 8'h10);
    wr(4'h5, 8'h12);
    chk(5, 16'h0000);
    wr(4'h2, 8'hC0);
    chk(4, 16'h0000);
    wr(4'h2, 8'h00);
    chk(4, 16'h0001);
    done("amp");
    for (int r = 0; r < 4; r++)
    begin
      wr(4'h4, {2'(r), 6'h00});
      count();
      chk(7, (r == 3) ? 16'h0000 : 16'(4 << r));
    end
    // Muted clocks sit at 0, so the pins show the polarity bits alone
    wr(4'h4, 8'hF0);
    // Both frame polarities flip together so R and S stay in step
    wr(4'h7, 8'hA1);
    chk(6, 16'h0001);
    chk(8, 16'h000C);
    wr(4'h4, 8'h00);
    count();
    chk(7, 16'h0004);
    done("format");
    summarize();
  end
endmodule
